// File: core/bocet_core.sv
// Instruction decoder with bit operations, calls and cycle timing.
`timescale 1ns/100ps
`include "bocet_cfg.svh"
module bocet_core (
   // Clock and reset.
   input  wire logic                  mclk,
   input  wire logic                  rst,
   // Instruction stream from program memory.
   input  wire logic                  instr_valid,
   input  wire logic [23:0]           instr_word,
   output logic                       instr_ready,
   // Operand values from the register datapath.
   input  wire logic [15:0]           operand_data,
   input  wire logic [15:0]           index_data,
   input  wire logic [4:0]            alu_flags,
   input  wire logic [1:0]            acc_ovf,
   input  wire logic [1:0]            acc_sat,
   // Operand write-back.
   output logic                       wr_en,
   output logic                       wr_to_wreg,
   output logic [12:0]                wr_faddr,
   output logic [3:0]                 wr_wreg,
   output logic [15:0]                wr_data,
   // Program flow.
   output logic                       pc_load,
   output logic [22:0]                pc_target,
   output logic                       call_push,
   output logic                       ret_pop,
   // Literal and width decode.
   output logic [15:0]                literal_out,
   output bocet_pkg::bocet_width_e    width_out,
   output logic                       lit_err,
   // Accumulator write-back.
   output logic                       awb_en,
   output logic                       awb_indirect,
   output logic [3:0]                 awb_reg,
   output logic                       awb_post_inc,
   // Status flags.
   output logic                       carry_flag,
   output logic                       digit_carry_flag,
   output logic                       negative_flag,
   output logic                       overflow_flag,
   output logic                       zero_flag,
   output logic                       acc_a_overflow_flag,
   output logic                       acc_b_overflow_flag,
   output logic                       acc_a_saturate_flag,
   output logic                       acc_b_saturate_flag,
   // Completion report.
   output logic                       instr_done,
   output logic [1:0]                 instr_cycles
);
   import bocet_pkg::*;

   function automatic logic is_two_word(input bocet_op_e o);
      is_two_word = (o == call_op) || (o == move_double_op);
   endfunction

   function automatic logic [1:0] flow_cycles(input bocet_op_e o);
      unique case (o)
         call_indirect_op, goto_indirect_op, branch_op, table_op:
            flow_cycles = `BOCET_CYC_FLOW;
         return_op, interrupt_return_op:
            flow_cycles = `BOCET_CYC_RET;
         default:
            flow_cycles = 2'h0;
      endcase
   endfunction

   bocet_state_e state;
   bocet_state_e next_state;
   logic [1:0]   stall_left;
   logic [1:0]   next_stall;
   logic [1:0]   cyc;
   logic [1:0]   next_cyc;
   logic         next_done;
   logic [1:0]   next_done_cyc;
   logic [15:0]  first_word;
   bocet_op_e    op;
   logic         take;
   logic         exec_take;
   logic         use_wreg;
   logic [3:0]   bit_pos;
   logic [15:0]  bit_mask;
   logic         tested;
   logic         skip_taken;
   logic [9:0]   lit10;
   logic         pending_call;

   assign op        = bocet_op_e'(instr_word[`BOCET_OPC_HI:`BOCET_OPC_LO]);
   assign take      = instr_valid && instr_ready;
   assign exec_take = take && (state == st_exec);
   assign use_wreg  = instr_word[`BOCET_WREG_BIT];
   assign lit10     = instr_word[`BOCET_LIT_HI:`BOCET_LIT_LO];

   // Bit position from a literal field or from the index register.
   always_comb begin
      if (use_wreg && instr_word[`BOCET_IDX_BIT] && op == bit_test_op) begin
         bit_pos = index_data[3:0];
      end else begin
         bit_pos = instr_word[`BOCET_BIT4_HI:`BOCET_BIT4_LO];
      end
   end
   assign bit_mask   = 16'h0001 << bit_pos;
   assign tested     = |(operand_data & bit_mask);
   assign skip_taken = (op == test_skip_if_clear_op && !tested) ||
                       (op == test_skip_if_set_op && tested);

   // Sequencing of instruction cycles.
   always_comb begin
      next_state    = state;
      next_stall    = stall_left;
      next_cyc      = cyc;
      next_done     = 1'b0;
      next_done_cyc = cyc;
      unique case (state)
         st_exec: if (take) begin
            next_cyc = `BOCET_CYC_ONE;
            if (is_two_word(op)) begin
               next_state = st_second;
            end else if (flow_cycles(op) != 2'h0) begin
               next_state = st_stall;
               next_stall = flow_cycles(op) - 2'h1;
            end else if (skip_taken) begin
               next_state = st_skip;
            end else begin
               next_done     = 1'b1;
               next_done_cyc = `BOCET_CYC_ONE;
            end
         end
         st_second: if (take) begin
            next_state    = st_exec;
            next_done     = 1'b1;
            next_done_cyc = `BOCET_CYC_TWO;
         end
         st_skip: if (take) begin
            if (is_two_word(op)) begin
               next_state = st_skip_tail;
               next_cyc   = `BOCET_CYC_TWO;
            end else begin
               next_state    = st_exec;
               next_done     = 1'b1;
               next_done_cyc = `BOCET_CYC_TWO;
            end
         end
         st_skip_tail: if (take) begin
            next_state    = st_exec;
            next_done     = 1'b1;
            next_done_cyc = `BOCET_CYC_RET;
         end
         st_stall: begin
            next_cyc = cyc + 2'h1;
            if (stall_left == 2'h1) begin
               next_state    = st_exec;
               next_done     = 1'b1;
               next_done_cyc = cyc + 2'h1;
            end else begin
               next_stall = stall_left - 2'h1;
            end
         end
         default: next_state = st_exec;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state        <= st_exec;
         stall_left   <= 2'h0;
         cyc          <= 2'h0;
         instr_ready  <= 1'b1;
         instr_done   <= 1'b0;
         instr_cycles <= 2'h0;
      end else begin
         state        <= next_state;
         stall_left   <= next_stall;
         cyc          <= next_cyc;
         instr_ready  <= (next_state != st_stall);
         instr_done   <= next_done;
         instr_cycles <= next_done_cyc;
      end
   end

   // Operand write-back of toggled or set bits.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_en      <= 1'b0;
         wr_to_wreg <= 1'b0;
         wr_faddr   <= 13'h0000;
         wr_wreg    <= 4'h0;
         wr_data    <= 16'h0000;
      end else begin
         wr_en <= exec_take &&
                  (op == bit_toggle_op || op == test_then_set_op);
         if (exec_take) begin
            wr_to_wreg <= use_wreg;
            wr_faddr   <= instr_word[`BOCET_FADDR_HI:`BOCET_FADDR_LO];
            wr_wreg    <= instr_word[`BOCET_WS_HI:`BOCET_WS_LO];
            if (op == bit_toggle_op) begin
               wr_data <= operand_data ^ bit_mask;
            end else begin
               wr_data <= operand_data | bit_mask;
            end
         end
      end
   end

   // Program counter loads for calls, jumps and branches.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         first_word <= 16'h0000;
         pc_load    <= 1'b0;
         pc_target  <= 23'h000000;
         call_push  <= 1'b0;
         ret_pop    <= 1'b0;
      end else begin
         pc_load   <= 1'b0;
         call_push <= 1'b0;
         ret_pop   <= exec_take &&
                      (op == return_op || op == interrupt_return_op);
         if (exec_take) begin
            first_word <= instr_word[`BOCET_TGT_LO_HI:0];
            if (op == call_indirect_op || op == goto_indirect_op ||
                op == branch_op) begin
               pc_load   <= 1'b1;
               call_push <= (op == call_indirect_op);
               pc_target <= {7'h00, operand_data[15:1], 1'b0};
            end
         end
         if (take && state == st_second && first_word != 16'h0000) begin
            pc_load <= 1'b0;
         end
         if (take && state == st_second && pending_call) begin
            pc_load   <= 1'b1;
            call_push <= 1'b1;
            pc_target <= {instr_word[`BOCET_TGT_HI_HI:0],
                          first_word[15:1], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pending_call <= 1'b0;
      end else if (exec_take) begin
         pending_call <= (op == call_op);
      end
   end

   // Literal range and operation width decode.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         literal_out <= 16'h0000;
         width_out   <= width_word;
         lit_err     <= 1'b0;
      end else if (exec_take && op == generic_op) begin
         unique case (instr_word[`BOCET_SIZE_HI:`BOCET_SIZE_LO])
            2'b01:   width_out <= width_byte;
            2'b10:   width_out <= width_double;
            default: width_out <= width_word;
         endcase
         if (instr_word[`BOCET_SIGNED_BIT]) begin
            literal_out <= {{6{lit10[9]}}, lit10};
            lit_err     <= 1'b0;
         end else begin
            literal_out <= {6'h00, lit10};
            lit_err     <= (instr_word[`BOCET_SIZE_HI:`BOCET_SIZE_LO] ==
                            2'b01) && (lit10 > `BOCET_BYTE_LIT_MAX);
         end
      end
   end

   // Accumulator write-back destination.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         awb_en       <= 1'b0;
         awb_indirect <= 1'b0;
         awb_reg      <= `BOCET_AWB_REG;
         awb_post_inc <= 1'b0;
      end else begin
         awb_en       <= 1'b0;
         awb_post_inc <= 1'b0;
         if (exec_take && op == accumulator_op) begin
            unique case (instr_word[`BOCET_AWB_HI:`BOCET_AWB_LO])
               2'b01: begin
                  awb_en       <= 1'b1;
                  awb_indirect <= 1'b0;
               end
               2'b10: begin
                  awb_en       <= 1'b1;
                  awb_indirect <= 1'b1;
                  awb_post_inc <= 1'b1;
               end
               default: awb_indirect <= 1'b0;
            endcase
         end
      end
   end

   // Status flags.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         {carry_flag, digit_carry_flag, negative_flag, overflow_flag,
          zero_flag, acc_a_overflow_flag, acc_b_overflow_flag,
          acc_a_saturate_flag, acc_b_saturate_flag} <= `BOCET_FLAGS_RST;
      end else if (exec_take) begin
         if (op == generic_op) begin
            {carry_flag, digit_carry_flag, negative_flag, overflow_flag,
             zero_flag} <= alu_flags;
         end
         if (op == bit_test_op || op == test_then_set_op) begin
            if (use_wreg && instr_word[`BOCET_VAR_C_BIT]) begin
               carry_flag <= tested;
            end else begin
               zero_flag <= !tested;
            end
         end
         if (op == accumulator_op) begin
            if (instr_word[`BOCET_ACC_SEL_BIT]) begin
               acc_b_overflow_flag <= acc_ovf[1];
               acc_b_saturate_flag <= acc_sat[1];
            end else begin
               acc_a_overflow_flag <= acc_ovf[0];
               acc_a_saturate_flag <= acc_sat[0];
            end
         end
      end
   end
endmodule

// File: core/bocet_cfg.svh
// Field positions, cycle counts, literal limit and reset values of the decoder.
// Operation
// - A plain single-word instruction ends in one cycle, and one that changes the program counter takes a second idle cycle, and a return a third.
// - Branches, indirect calls and jumps, table accesses and returns take two or three cycles though they are one word long.
// - A skip that is taken costs two cycles over a one-word target and three over a two-word target; a skip not taken costs one.
// - Every two-word instruction, the double-word move among them, takes exactly two cycles.
// - Bit operations pick their bit with a four-bit position, and the toggle inverts that bit and touches no flag.
// - Test-and-skip-if-clear skips the next instruction when the chosen bit is zero and touches no flag.
// - Test-and-skip-if-set skips the next instruction when the chosen bit is one and touches no flag.
// - Bit test puts the inverse of the chosen bit in zero, or the bit itself in carry, as the variant says, the position coming from a literal or a register,
//   and the set variant, its position always from a literal, then forces the bit to one.
// - The direct call is two words and two cycles with a 23-bit even target; the indirect call is one word and two cycles.
// - File-register operands are direct data addresses from zero to 0x1FFF.
// - An unsigned 10-bit literal spans 0 to 255 in byte mode and 0 to 1023 in word mode; a signed one spans -512 to 511.
// - Operations are word wide unless a byte or double-word suffix is given.
// - There are two accumulators, written back only to register 13 or to the place it points at with a post-increment of two.
// - Each accumulator has its own overflow and saturation flags besides carry, digit carry, negative, overflow and zero.
`ifndef BOCET_CFG_SVH
`define BOCET_CFG_SVH
`define BOCET_OPC_HI      23
`define BOCET_OPC_LO      19
`define BOCET_WREG_BIT    18
`define BOCET_ACC_SEL_BIT 18
`define BOCET_VAR_C_BIT   17
`define BOCET_AWB_HI      17
`define BOCET_AWB_LO      16
`define BOCET_BIT4_HI     16
`define BOCET_BIT4_LO     13
`define BOCET_SIGNED_BIT  12
`define BOCET_FADDR_HI    12
`define BOCET_FADDR_LO    0
`define BOCET_SIZE_HI     11
`define BOCET_SIZE_LO     10
`define BOCET_LIT_HI      9
`define BOCET_LIT_LO      0
`define BOCET_IDX_BIT     8
`define BOCET_WB_HI       7
`define BOCET_WB_LO       4
`define BOCET_WS_HI       3
`define BOCET_WS_LO       0
`define BOCET_TGT_LO_HI   15
`define BOCET_TGT_HI_HI   6
`define BOCET_BYTE_LIT_MAX 10'h0FF
`define BOCET_AWB_REG     4'hD
`define BOCET_CYC_ONE     2'h1
`define BOCET_CYC_TWO     2'h2
`define BOCET_CYC_FLOW    2'h2
`define BOCET_CYC_RET     2'h3
`define BOCET_FLAGS_RST   9'h000
`endif

// File: core/bocet_pkg.sv
// Types shared by the bit-operation and call decoder.
package bocet_pkg;
   typedef enum logic [4:0] {
      nop_op                = 5'h00,
      generic_op            = 5'h01,
      bit_toggle_op         = 5'h02,
      test_skip_if_clear_op = 5'h03,
      test_skip_if_set_op   = 5'h04,
      bit_test_op           = 5'h05,
      test_then_set_op      = 5'h06,
      call_op               = 5'h07,
      call_indirect_op      = 5'h08,
      goto_indirect_op      = 5'h09,
      branch_op             = 5'h0A,
      table_op              = 5'h0B,
      return_op             = 5'h0C,
      interrupt_return_op   = 5'h0D,
      move_double_op        = 5'h0E,
      accumulator_op        = 5'h0F
   } bocet_op_e;
   typedef enum logic [2:0] {
      st_exec      = 3'b000,
      st_second    = 3'b001,
      st_skip      = 3'b010,
      st_skip_tail = 3'b011,
      st_stall     = 3'b100
   } bocet_state_e;
   typedef enum logic [1:0] {
      width_word   = 2'b00,
      width_byte   = 2'b01,
      width_double = 2'b10
   } bocet_width_e;
endpackage

// File: testbench/bocet_properties.sv
// Port-level checks of the decoder's timing and bit operations.
`timescale 1ns/100ps
module bocet_properties (
   // Clock and reset.
   input wire logic        mclk,
   input wire logic        rst,
   // Instruction stream.
   input wire logic        instr_valid,
   input wire logic [23:0] instr_word,
   input wire logic        instr_ready,
   input wire logic [15:0] operand_data,
   // Results.
   input wire logic        wr_en,
   input wire logic [15:0] wr_data,
   input wire logic        pc_load,
   input wire logic [22:0] pc_target,
   input wire logic        call_push,
   input wire logic        ret_pop,
   input wire logic        zero_flag,
   input wire logic        carry_flag,
   input wire logic        instr_done,
   input wire logic [1:0]  instr_cycles
);
   import bocet_pkg::*;
   logic        tk, bv, bq, sk;
   logic [1:0]  tail;
   logic [4:0]  op;
   logic [23:0] w;
   logic [15:0] d;
   assign tk = instr_valid && instr_ready && tail == 2'h0;
   assign op = instr_word[23:19];
   assign bv = operand_data[instr_word[16:13]];
   assign sk = tk && ((op == test_skip_if_clear_op && !bv) ||
                      (op == test_skip_if_set_op && bv));
   // Word and operand of the taking edge, for results one cycle on.
   always_ff @(posedge mclk) begin
      w <= instr_word;
      d <= operand_data;
      bq <= bv;
   end
   // Second words and skipped words are not new instructions.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tail <= 2'h0;
      end else if (instr_valid && instr_ready) begin
         if (tail == 2'h1) begin
            tail <= 2'h0;
         end else if (op == call_op || op == move_double_op) begin
            tail <= 2'h1;
         end else begin
            tail <= sk ? 2'h2 : 2'h0;
         end
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   property p_tgl;
      tk && op == bit_toggle_op |=> wr_en && instr_done &&
         instr_cycles == 2'h1 && wr_data == (d ^ (16'h0001 << w[16:13]));
   endproperty
   a_tgl: assert property (p_tgl) else $error("toggle wrong");
   property p_tts;
      tk && op == test_then_set_op |=>
         wr_en && wr_data == (d | (16'h0001 << w[16:13]));
   endproperty
   a_tts: assert property (p_tts) else $error("set wrong");
   property p_quiet;
      tk && op inside {bit_toggle_op, test_skip_if_clear_op,
         test_skip_if_set_op} |=> $stable(zero_flag) && $stable(carry_flag);
   endproperty
   a_quiet: assert property (p_quiet) else $error("flag moved");
   property p_skip;
      sk |=> !instr_done ##[1:2] (instr_done && instr_cycles != 2'h1);
   endproperty
   a_skip: assert property (p_skip) else $error("skip wrong");
   property p_bit_test_op;
      tk && op inside {bit_test_op, test_then_set_op} && !instr_word[18]
         |=> zero_flag == !bq;
   endproperty
   a_bit_test_op: assert property (p_bit_test_op) else $error("zero wrong");
   property p_flow;
      tk && op inside {call_indirect_op, goto_indirect_op, branch_op,
         table_op} |=> pc_load == (w[23:19] != table_op) &&
         !instr_ready ##1 instr_done && instr_cycles == 2'h2;
   endproperty
   a_flow: assert property (p_flow) else $error("flow wrong");
   property p_ret;
      tk && op inside {return_op, interrupt_return_op} |=>
         ret_pop && !instr_ready ##1 !instr_ready ##1
         instr_done && instr_cycles == 2'h3;
   endproperty
   a_ret: assert property (p_ret) else $error("return wrong");
   property p_call;
      tk && op == call_op |=> ##[1:8] (call_push && pc_load &&
         !pc_target[0] && instr_done && instr_cycles == 2'h2);
   endproperty
   a_call: assert property (p_call) else $error("call wrong");
endmodule
bind bocet_core bocet_properties u_props (
   .mclk(mclk), .rst(rst), .instr_valid(instr_valid),
   .instr_word(instr_word), .instr_ready(instr_ready),
   .operand_data(operand_data), .wr_en(wr_en), .wr_data(wr_data),
   .pc_load(pc_load), .pc_target(pc_target), .call_push(call_push),
   .ret_pop(ret_pop),
   .zero_flag(zero_flag), .carry_flag(carry_flag),
   .instr_done(instr_done), .instr_cycles(instr_cycles)
);

// File: testbench/bocet_pmem.sv
// Program memory model offering instruction words with their operands.
`timescale 1ns/100ps
module bocet_pmem (
   // Clock and reset.
   input  wire logic   mclk,
   input  wire logic   rst,
   // Pacing and handshake.
   input  wire logic   gap,
   input  wire logic   instr_ready,
   // Offered word and the operand that goes with it.
   output logic        instr_valid,
   output logic [23:0] instr_word,
   output logic [15:0] operand_data
);
   logic [39:0] q[$];
   logic        took = 1'b0;
   logic        idle = 1'b0;
   initial {instr_valid, instr_word, operand_data} = 41'h0;
   task automatic push(input logic [39:0] x);
      q.push_back(x);
   endtask
   always @(posedge mclk) begin
      if (!rst && instr_valid && instr_ready) begin
         void'(q.pop_front());
         took = 1'b1;
      end
   end
   // An offer holds until taken; an idle line shows a changing pattern.
   always @(negedge mclk) begin
      idle = ~idle;
      if (took || !instr_valid) begin
         instr_valid = q.size() > 0 && !(gap && idle);
         {operand_data, instr_word} = instr_valid ? q[0] :
            ~{operand_data, instr_word};
      end
      took = 1'b0;
   end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the bit-operation and call decoder.
`timescale 1ns/100ps
module tb_top;
   import bocet_pkg::*;
   typedef struct packed {
      logic [1:0]  cyc;
      logic [2:0]  kind;
      logic [31:0] val;
   } bocet_exp_s;
   logic         mclk = 1'b0;
   logic         rst = 1'b1;
   logic         gap = 1'b0;
   logic         instr_valid, instr_ready, lit_err, instr_done;
   logic         wr_en, wr_to_wreg, pc_load, call_push, c_f, dc_f, n_f;
   logic         ov_f, z_f, oa, ob, sa, sb;
   logic         awb_en, awb_ind, awb_pi;
   logic [3:0]   af = 4'h0;
   logic [23:0]  instr_word;
   logic [15:0]  operand_data, wr_data, literal_out;
   logic [15:0]  index_data = 16'h0000;
   logic [12:0]  wr_faddr;
   logic [3:0]   wr_wreg, awb_reg;
   logic [22:0]  pc_target, tgt;
   logic [4:0]   alu_flags = 5'h00;
   logic [1:0]   acc_ovf = 2'h0;
   logic [1:0]   acc_sat = 2'h0;
   logic [1:0]   instr_cycles, sz;
   bocet_width_e width_out, wd;
   bocet_exp_s   eq[$];
   bocet_exp_s   e;
   logic [31:0]  s;
   logic [9:0]   lit;
   int           i;
   int           failures = 0;
   int           cmp_count = 0;
   always #2.5 mclk = ~mclk;
   bocet_pmem u_mem (.mclk, .rst, .gap, .instr_ready, .instr_valid,
      .instr_word, .operand_data);
   bocet_core u_dut (.mclk, .rst, .instr_valid, .instr_word, .instr_ready,
      .operand_data, .index_data, .alu_flags, .acc_ovf, .acc_sat, .wr_en,
      .wr_to_wreg, .wr_faddr, .wr_wreg, .wr_data, .pc_load, .pc_target,
      .call_push, .ret_pop(), .literal_out, .width_out, .lit_err,
      .awb_en, .awb_indirect(awb_ind), .awb_reg, .awb_post_inc(awb_pi),
      .carry_flag(c_f), .digit_carry_flag(dc_f), .negative_flag(n_f),
      .overflow_flag(ov_f), .zero_flag(z_f), .acc_a_overflow_flag(oa),
      .acc_b_overflow_flag(ob), .acc_a_saturate_flag(sa),
      .acc_b_saturate_flag(sb), .instr_done, .instr_cycles);
   task automatic results();
      if (failures == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         failures++;
         $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, want);
      end
   endtask
   task automatic put(input logic [23:0] w, input logic [15:0] o);
      u_mem.push({o, w});
   endtask
   task automatic note(input logic [1:0] c, input logic [2:0] k,
      input logic [31:0] v);
      eq.push_back({c, k, v});
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (eq.size() > 0 && n < 600) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 600) begin
         failures++;
         $display("[ERR] %0t ns: result never came", $time);
         results();
      end
   endtask
   task automatic bitop(input logic [4:0] op, input logic ws, input logic c,
      input logic [3:0] b, input logic [12:0] f, input logic [15:0] o);
      logic [15:0] m;
      logic        k;
      m = 16'h0001 << ((op == bit_test_op && ws && f[8]) ?
         index_data[3:0] : b);
      k = |(o & m);
      put({op, ws, c, b, f}, o);
      if (op == bit_toggle_op) begin
         note(2'h1, 3'h1, {2'b01, ws, ws ? {9'h000, f[3:0]} : f, o ^ m});
      end else begin
         note(2'h1, (ws && c) ? 3'h3 : 3'h2, 32'((ws && c) ? k : !k));
      end
   endtask
   task automatic skp(input logic [4:0] op, input logic bs, input logic two);
      logic [3:0]  b;
      logic [15:0] o;
      b = 4'($urandom);
      o = 16'($urandom);
      o[b] = bs;
      put({op, 2'b00, b, 13'($urandom)}, o);
      put(two ? {move_double_op, 19'h00000} : 24'h000000, o);
      if (two) put(24'h000000, o);
      if ((op == test_skip_if_set_op) == bs) begin
         note(two ? 2'h3 : 2'h2, 3'h0, 32'h0);
      end else begin
         note(2'h1, 3'h0, 32'h0);
         note(two ? 2'h2 : 2'h1, 3'h0, 32'h0);
      end
   endtask
   always @(negedge mclk) begin
      if (!rst && instr_done && eq.size() == 0) chk(32'h1, 32'h0);
      if (!rst && instr_done && eq.size() > 0) begin
         e = eq.pop_front();
         case (e.kind)
            3'h1: s = {1'b0, wr_en, wr_to_wreg,
                       wr_to_wreg ? {9'h000, wr_wreg} : wr_faddr, wr_data};
            3'h2: s = 32'(z_f);
            3'h3: s = 32'(c_f);
            3'h4: s = {7'h00, call_push, pc_load, pc_target};
            3'h5: s = {8'h00, c_f, dc_f, n_f, ov_f, z_f, width_out, lit_err,
                       literal_out};
            3'h6: s = {25'h0000000, awb_en, awb_ind, awb_pi, sb, sa, ob, oa};
            default: s = 32'h0;
         endcase
         chk(32'(instr_cycles), 32'(e.cyc));
         chk(s, e.val);
      end
   end
   initial begin
      void'($urandom(69));
      index_data = 16'($urandom);
      repeat (5) @(posedge mclk);
      chk(32'({instr_ready, awb_reg, width_out}), {25'h1, 4'hD, 2'h0});
      @(negedge mclk) rst = 1'b0;
      gap = 1'b1;
      for (i = 0; i < 48; i++) begin
         bitop(i % 3 == 0 ? bit_toggle_op : i % 3 == 1 ? bit_test_op :
            test_then_set_op, 1'($urandom), 1'($urandom), 4'(i / 3),
            i == 0 ? 13'h1FFF : 13'($urandom), 16'($urandom));
      end
      drain();
      gap = 1'b0;
      for (i = 0; i < 8; i++) begin
         skp(i[0] ? test_skip_if_set_op : test_skip_if_clear_op, i[1], i[2]);
      end
      tgt = 23'($urandom) & 23'h7FFFFE;
      put({call_op, 3'h0, tgt[15:1], 1'($urandom)}, 16'h0000);
      put({17'h00000, tgt[22:16]}, 16'h0000);
      note(2'h2, 3'h4, {9'h003, tgt});
      for (i = 8; i < 14; i++) begin
         put({5'(i), 19'($urandom)}, 16'h0000);
         note(i < 12 ? 2'h2 : 2'h3, 3'h0, 32'h0);
      end
      put(24'hF80000, 16'h0000);
      note(2'h1, 3'h0, 32'h0);
      drain();
      // Literal boundaries in every width and signedness.
      for (i = 0; i < 24; i++) begin
         lit = i % 4 == 0 ? 10'h0FF : i % 4 == 1 ? 10'h100 :
            i % 4 == 2 ? 10'h3FF : 10'h200;
         sz = 2'(i / 8);
         wd = sz == 2'h1 ? width_byte : sz == 2'h2 ? width_double : width_word;
         @(negedge mclk) alu_flags = 5'($urandom);
         put({generic_op, 6'h00, i[2], sz, lit}, 16'h0000);
         note(2'h1, 3'h5, {8'h00, alu_flags, wd,
            !i[2] && sz == 2'h1 && lit > 10'h0FF,
            i[2] ? {{6{lit[9]}}, lit} : {6'h00, lit}});
         drain();
      end
      for (i = 0; i < 8; i++) begin
         @(negedge mclk);
         acc_ovf = 2'($urandom);
         acc_sat = 2'($urandom);
         put({accumulator_op, i[2], i[1:0], 16'h0000}, 16'h0000);
         if (i[2]) begin
            af[3] = acc_sat[1];
            af[1] = acc_ovf[1];
         end else begin
            af[2] = acc_sat[0];
            af[0] = acc_ovf[0];
         end
         note(2'h1, 3'h6, {25'h0000000, i[1] ^ i[0], i[1] && !i[0],
            i[1] && !i[0], af});
         drain();
      end
      repeat (4) @(negedge mclk);
      results();
   end
endmodule
